/* File: shared/tsi_defs.vh */
// constants shared by the temperature sensor two-wire slave front end
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH
// register pointer offsets
`define TSI_PTR_RESET 8'h00
`define TSI_OFS_CONFIG1 8'h09
`define TSI_OFS_ONE_SHOT_TRIGGER 8'h0F
// field positions
`define TSI_SHUTDOWN_BIT 6
// reset values
`define TSI_CONFIG1_RESET 8'h00
// addresses of the strap variant
`define TSI_ADDR_FL_0 7'h1C
`define TSI_ADDR_FL_1 7'h1D
`define TSI_ADDR_0_FL 7'h1E
`define TSI_ADDR_1_FL 7'h1F
`define TSI_ADDR_FL_FL 7'h2A
`define TSI_ADDR_BASE 7'h4C
// factory preset addresses of the triple variant
`define TSI_ADDR_PRESET_A 7'h4C
`define TSI_ADDR_PRESET_B 7'h4D
// high speed master code pattern, upper five bits
`define TSI_HS_CODE_TOP 5'h01
// variant codes
`define TSI_VAR_STRAP 2'h0
`define TSI_VAR_POLARITY 2'h1
`define TSI_VAR_PRESET 2'h2
// polarity probe settle time in ns, and cycles at 40 ns
`define TSI_PROBE_NS 2000
`define TSI_CLK_NS 40
`define TSI_PROBE_CYC ((`TSI_PROBE_NS + `TSI_CLK_NS - 1) / `TSI_CLK_NS)
`endif

/* File: verilog/tsi_sync.v */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module tsi_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // asynchronous levels and their synchronised copies
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage1; // first stage, read only by the second

  // reset to the bus idle level so no false start is seen
  always @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= {WIDTH{1'b1}};
      sync_o <= {WIDTH{1'b1}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

/* File: verilog/tsi_addr_sel.v */
// slave address selection: straps, diode polarity probe or factory preset
`timescale 1ns/1ns
`include "tsi_defs.vh"
module tsi_addr_sel #(
  parameter [1:0] VARIANT = `TSI_VAR_STRAP,
  parameter [6:0] PRESET_ADDR = `TSI_ADDR_PRESET_A,
  parameter PROBE_CYC = `TSI_PROBE_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // restart the probe (software reset)
  input wire restart_i,
  // strap levels, synchronised: high, low, and floating flag per pin
  input wire [1:0] strap_level_i,
  input wire [1:0] strap_float_i,
  // sensor pins pulled up near supply, synchronised (pins one to four)
  input wire [3:0] pin_high_i,
  // probe drive: current source and 0.6 v clamp per sensor pin
  output reg [3:0] probe_source_o,
  output reg [3:0] probe_clamp_o,
  // selected address and done flag
  output reg [6:0] addr_o,
  output reg done_o,
  // polarity: high means the even pin of the pair is the positive input
  output reg [1:0] pol_swap_o
);
  localparam S_P1 = 4'b0001; // drive first pin of a pair
  localparam S_P2 = 4'b0010; // drive second pin of a pair
  localparam S_NEXT = 4'b0100; // move to next channel
  localparam S_DONE = 4'b1000;
  reg [3:0] state;
  reg ch; // channel being probed
  reg [15:0] cnt; // settle counter
  // compare at full integer width so a large settle count is not cut short
  wire settled = ({16'h0000, cnt} == PROBE_CYC - 1);

  // strap mapping; unchanged when all probing is left out
  function [6:0] strap_map;
    input [1:0] lvl;
    input [1:0] flt;
    begin
      // a floating pin hides its level, whatever the comparator says
      if (flt == 2'b11)
        strap_map = `TSI_ADDR_FL_FL; // [R1]
      else if (flt[1])
        strap_map = lvl[0] ? `TSI_ADDR_FL_1 : `TSI_ADDR_FL_0; // [R1]
      else if (flt[0])
        strap_map = lvl[1] ? `TSI_ADDR_1_FL : `TSI_ADDR_0_FL; // [R1]
      else
        strap_map = `TSI_ADDR_BASE | {5'h00, lvl};
    end
  endfunction

  // probe walk: pin one of the pair first, then pin two if needed
  always @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      state <= S_P1;
      ch <= 1'b0;
      cnt <= 16'h0000;
      pol_swap_o <= 2'b00;
      probe_source_o <= 4'h0;
      probe_clamp_o <= 4'h0;
      done_o <= 1'b0;
      addr_o <= 7'h00;
    end else begin
      case (state)
        S_P1: begin
          probe_source_o <= ch ? 4'h4 : 4'h1; // [R3] [R6]
          probe_clamp_o <= ch ? 4'h8 : 4'h2;
          cnt <= settled ? 16'h0000 : cnt + 16'h0001;
          if (settled) begin
            if (!pin_high_i[{ch, 1'b0}]) begin
              pol_swap_o[ch] <= 1'b0; // [R3]
              state <= S_NEXT;
            end else begin
              state <= S_P2; // [R4]
            end
          end
        end
        S_P2: begin
          probe_source_o <= ch ? 4'h8 : 4'h2; // [R4]
          probe_clamp_o <= ch ? 4'h4 : 4'h1;
          cnt <= settled ? 16'h0000 : cnt + 16'h0001;
          if (settled) begin
            // both open: pin one stays positive, bit cleared
            pol_swap_o[ch] <= !pin_high_i[{ch, 1'b1}]; // [R4] [R5]
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          probe_source_o <= 4'h0;
          probe_clamp_o <= 4'h0;
          ch <= 1'b1;
          state <= ch ? S_DONE : S_P1; // [R6]
        end
        S_DONE: begin
          done_o <= 1'b1;
          if (VARIANT == `TSI_VAR_POLARITY)
            addr_o <= `TSI_ADDR_BASE | {5'h00, pol_swap_o[0], pol_swap_o[1]}; // [R2] [R7]
          else if (VARIANT == `TSI_VAR_PRESET)
            addr_o <= PRESET_ADDR; // [R8]
          else
            addr_o <= strap_map(strap_level_i, strap_float_i); // [R1]
        end
        default: state <= S_P1;
      endcase
    end
  end
endmodule

/* File: verilog/tsi_slave.v */
// two-wire slave front end of a remote diode temperature monitor
//
// Overview of operation
// R1 - strap pins pick one of nine addresses
// R2 - diode polarity picks one of four addresses
// R3 - probe pin one; low means bit cleared
// R4 - else probe pin two; low sets bit
// R5 - both shorted or open: pin one, bit clear
// R6 - repeat probe on pins three and four
// R7 - channel two sets lsb, channel one next
// R8 - triple variant answers fixed preset address only
// R9 - first written byte loads register pointer
// R10 - pointer-only write accepted as pointer update
// R11 - reads use last written pointer, persisting
// R12 - msb first, high byte before low byte
// R13 - master ends reads with not-acknowledge
// R14 - master sends high-speed code after start
// R15 - high-speed code not acknowledged, filters switched
// R16 - high-speed kept until stop condition
// R17 - trigger write in shutdown starts one conversion
// R18 - trigger data byte discarded
// R19 - trigger ignored while conversion running
// R20 - shutdown is config one bit six
// R21 - pointer eight bits, resets to zero
// R22 - acknowledge own address and written bytes only
`timescale 1ns/1ns
`include "tsi_defs.vh"
module tsi_slave #(
  parameter [1:0] VARIANT = `TSI_VAR_STRAP,
  parameter [6:0] PRESET_ADDR = `TSI_ADDR_PRESET_A,
  parameter PROBE_CYC = `TSI_PROBE_CYC
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // two-wire bus pins, open drain
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  // address straps
  input wire address_select_upper_i,
  input wire address_select_upper_float_i,
  input wire address_select_lower_i,
  input wire address_select_lower_float_i,
  // sensor pins: near-supply comparators and probe drives
  input wire [3:0] sensor_pin_high_i,
  output reg [3:0] probe_source_o,
  output reg [3:0] probe_clamp_o,
  // register file side: read data, write strobe, software reset
  input wire [15:0] reg_rdata_i,
  input wire reg_two_byte_i,
  output reg [7:0] reg_ptr_o,
  output reg reg_wr_o,
  output reg [7:0] reg_wdata_o,
  input wire soft_reset_i,
  // conversion engine
  input wire conv_busy_i,
  output reg conv_start_o,
  output reg shutdown_control_o,
  // filter mode and selected address
  output reg hs_mode_o,
  output reg [6:0] slave_addr_o,
  output reg addr_valid_o
);
  localparam ST_IDLE = 5'b00001; // waiting for start
  localparam ST_RX = 5'b00010; // shifting in a byte
  localparam ST_ACK = 5'b00100; // ack slot of received byte
  localparam ST_TX = 5'b01000; // shifting out a byte
  localparam ST_MACK = 5'b10000; // master ack slot after sent byte

  wire [1:0] bus_s; // synchronised scl, sda
  wire [3:0] strap_s; // synchronised strap levels and float flags
  wire [3:0] pin_s; // synchronised sensor comparators
  wire [6:0] sel_addr;
  wire sel_done;
  wire [3:0] src;
  wire [3:0] clm;
  reg scl_d; // previous synchronised scl
  reg sda_d; // previous synchronised sda
  reg [4:0] state;
  reg [7:0] shreg; // byte shift register
  reg [3:0] bitcnt; // bits handled in current byte
  reg is_read; // current transfer direction
  reg first_byte; // next received data byte is the pointer
  reg addr_phase; // next received byte is an address
  reg ack_this; // drive ack for current byte
  reg low_next; // next sent byte is the low half
  reg [7:0] config1; // shutdown bit lives here

  tsi_sync #(.WIDTH(2)) u_bus_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i}),
    .sync_o(bus_s)
  );

  tsi_sync #(.WIDTH(8)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({address_select_upper_float_i, address_select_lower_float_i,
              address_select_upper_i, address_select_lower_i, sensor_pin_high_i}),
    .sync_o({strap_s, pin_s})
  );

  tsi_addr_sel #(
    .VARIANT(VARIANT),
    .PRESET_ADDR(PRESET_ADDR),
    .PROBE_CYC(PROBE_CYC)
  ) u_addr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(soft_reset_i),
    .strap_level_i(strap_s[1:0]),
    .strap_float_i(strap_s[3:2]),
    .pin_high_i(pin_s),
    .probe_source_o(src),
    .probe_clamp_o(clm),
    .addr_o(sel_addr),
    .done_o(sel_done),
    .pol_swap_o()
  );

  wire scl = bus_s[1];
  wire sda = bus_s[0];
  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_cond = scl && scl_d && sda_d && !sda; // falling sda, scl high
  wire stop_cond = scl && scl_d && !sda_d && sda; // rising sda, scl high
  wire [7:0] rx_byte = {shreg[6:0], sda};
  // byte that goes out next: high half first
  wire [7:0] tx_byte = low_next ? reg_rdata_i[7:0] : reg_rdata_i[15:8]; // [R12]

  // edge history of the synchronised bus
  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // registered copies of the selected address and probe drives
  always @(posedge clk_i) begin
    if (rst_i) begin
      slave_addr_o <= 7'h00;
      addr_valid_o <= 1'b0;
      probe_source_o <= 4'h0;
      probe_clamp_o <= 4'h0;
    end else begin
      slave_addr_o <= sel_addr;
      addr_valid_o <= sel_done;
      probe_source_o <= src;
      probe_clamp_o <= clm;
    end
  end

  // protocol engine: bytes, acks, pointer and register writes
  always @(posedge clk_i) begin
    if (rst_i || soft_reset_i) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      is_read <= 1'b0;
      first_byte <= 1'b0;
      addr_phase <= 1'b0;
      ack_this <= 1'b0;
      low_next <= 1'b0;
      sda_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
      reg_ptr_o <= `TSI_PTR_RESET; // [R21]
      reg_wr_o <= 1'b0;
      reg_wdata_o <= 8'h00;
      conv_start_o <= 1'b0;
      config1 <= `TSI_CONFIG1_RESET;
      shutdown_control_o <= 1'b0;
      hs_mode_o <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      conv_start_o <= 1'b0;
      shutdown_control_o <= config1[`TSI_SHUTDOWN_BIT]; // [R20]
      if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
        hs_mode_o <= 1'b0; // [R16]
      end else if (start_cond) begin
        // repeated start keeps the pointer
        state <= ST_RX;
        bitcnt <= 4'h0;
        addr_phase <= 1'b1;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: sda_oe_n_o <= 1'b1;
          ST_RX: begin
            if (scl_rise) begin
              shreg <= rx_byte;
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              ack_this <= 1'b0;
              state <= ST_ACK;
              if (addr_phase) begin
                addr_phase <= 1'b0;
                if (shreg[7:3] == `TSI_HS_CODE_TOP) begin
                  hs_mode_o <= 1'b1; // [R15] no ack, wait for next start
                  state <= ST_IDLE;
                end else if (addr_valid_o && shreg[7:1] == slave_addr_o) begin
                  ack_this <= 1'b1; // [R22]
                  is_read <= shreg[0];
                  first_byte <= !shreg[0];
                  low_next <= 1'b0;
                  sda_o <= 1'b0;
                  sda_oe_n_o <= 1'b0;
                end else begin
                  state <= ST_IDLE; // [R22] other address ignored
                end
              end else begin
                ack_this <= 1'b1; // [R22]
                sda_o <= 1'b0;
                sda_oe_n_o <= 1'b0;
                if (first_byte) begin
                  reg_ptr_o <= shreg; // [R9] [R10]
                  first_byte <= 1'b0;
                end else begin
                  reg_wr_o <= 1'b1;
                  reg_wdata_o <= shreg;
                  if (reg_ptr_o == `TSI_OFS_CONFIG1)
                    config1 <= shreg;
                  // data value dropped; busy conversions win over trigger
                  if (reg_ptr_o == `TSI_OFS_ONE_SHOT_TRIGGER &&
                      config1[`TSI_SHUTDOWN_BIT] && !conv_busy_i)
                    conv_start_o <= 1'b1; // [R17] [R18] [R19]
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                // pointer is not touched by reads
                sda_o <= tx_byte[7]; // [R11] [R12]
                sda_oe_n_o <= 1'b0;
                shreg <= {tx_byte[6:0], 1'b0};
                bitcnt <= 4'h1;
                low_next <= reg_two_byte_i && !low_next;
                state <= ST_TX;
              end else begin
                sda_oe_n_o <= 1'b1;
                state <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe_n_o <= 1'b1;
                state <= ST_MACK;
              end else begin
                sda_o <= shreg[7]; // [R12]
                shreg <= {shreg[6:0], 1'b0};
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // not-acknowledge ends the read
              state <= sda ? ST_IDLE : ST_ACK; // [R13]
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

/* File: dv/tsi_slave_checker.sv */
// assertion checker for the two-wire slave front end
`timescale 1ns/1ns
module tsi_slave_checker (
  // clock, reset and bus pins
  input wire clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  // watched ports
  input wire sda_oe_n_o,
  input wire [7:0] reg_ptr_o,
  input wire reg_wr_o,
  input wire [7:0] reg_wdata_o,
  input wire conv_busy_i,
  input wire conv_start_o,
  input wire shutdown_control_o,
  input wire hs_mode_o,
  input wire addr_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reg sd_want; // shutdown bit last written to config one
  // keep the written bit; the register may land a cycle later
  always @(posedge clk_i) begin
    if (rst_i) sd_want <= 1'b0;
    else if (reg_wr_o && reg_ptr_o == 8'h09) sd_want <= reg_wdata_o[6];
  end
  // config one write and stop condition on the pins
  sequence cfg_wr;
    reg_wr_o && reg_ptr_o == 8'h09;
  endsequence
  sequence stop_seen;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  AST_PTR_RST: assert property ($fell(rst_i) |-> reg_ptr_o == 8'h00)
    else $error("pointer not zero after reset");
  AST_SDA_ADDR: assert property (!sda_oe_n_o |-> addr_valid_o)
    else $error("bus driven before address chosen");
  AST_HS_STOP: assert property (stop_seen |-> ##[1:8] !hs_mode_o)
    else $error("fast filters not restored after stop");
  AST_HS_NACK: assert property ($rose(hs_mode_o) |-> sda_oe_n_o [*8])
    else $error("high speed code acknowledged");
  AST_START_COND: assert property (conv_start_o |-> reg_wr_o && shutdown_control_o
    && reg_ptr_o == 8'h0F)
    else $error("one shot start without trigger write in shutdown");
  AST_ONE_PULSE: assert property (conv_start_o |=> !conv_start_o)
    else $error("one shot start longer than a cycle");
  AST_BUSY_IGN: assert property (conv_busy_i && $past(conv_busy_i) |-> !conv_start_o)
    else $error("one shot started while busy");
  AST_SD_WRITE: assert property (cfg_wr |-> ##2 shutdown_control_o == sd_want)
    else $error("shutdown bit not taken from config write");
endmodule
bind tsi_slave tsi_slave_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_oe_n_o(sda_oe_n_o), .reg_ptr_o(reg_ptr_o), .reg_wr_o(reg_wr_o),
  .reg_wdata_o(reg_wdata_o), .conv_busy_i(conv_busy_i), .conv_start_o(conv_start_o),
  .shutdown_control_o(shutdown_control_o), .hs_mode_o(hs_mode_o),
  .addr_valid_o(addr_valid_o));

/* File: dv/tsi_bus_master.sv */
// two-wire bus master model: makes the bus clock and pulls data low
`timescale 1ns/1ns
module tsi_bus_master (
  // bus clock and data pull-down
  output reg scl_o,
  output reg sda_low_o,
  // wired data level
  input wire sda_i
);
  // idle released; the clock stands high outside frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // one 320 ns bit; data moves only while the clock is low
  task bit_io(input b, output s);
    begin
      #40 sda_low_o = !b;
      #160 scl_o = 1'b1;
      #80 s = sda_i;
      #40 scl_o = 1'b0;
    end
  endtask
  // start or repeated start, then the first byte follows
  task start;
    begin
      #40 sda_low_o = 1'b0;
      #160 scl_o = 1'b1;
      #120 sda_low_o = 1'b1;
      #120 scl_o = 1'b0;
    end
  endtask
  // stop: data rises while the clock is high, then the bus rests
  task stop;
    begin
      #40 sda_low_o = 1'b1;
      #160 scl_o = 1'b1;
      #120 sda_low_o = 1'b0;
      #200;
    end
  endtask
  // send a byte msb first and return the acknowledge level
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], s);
      bit_io(1'b1, ack);
    end
  endtask
  // read a byte; last byte left high to end the read
  task rbyte(input last, output [7:0] d);
    integer i;
    reg s;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
      bit_io(last, s);
    end
  endtask
endmodule

/* File: dv/tsi_slave_test.sv */
// self-checking bench for the two-wire slave front end
`timescale 1ns/1ns
module tsi_slave_test;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg up = 1'b0, upf = 1'b0, lo = 1'b0, lof = 1'b0; // straps and float flags
  reg [3:0] pins = 4'h0; // sensor comparators, unused by straps
  reg [15:0] rdata = 16'h0000; // register read data
  reg busy = 1'b0; // conversion running
  wire scl, sda, m_low, sda_o, sda_oe_n_o, conv_start_o, shutdown_control_o, hs_mode_o;
  wire addr_valid_o;
  wire [7:0] reg_ptr_o;
  wire [6:0] slave_addr_o;
  integer seed = 32'h95c3987a;
  integer n_fail = 0, total_checks = 0, n_start = 0, k, n;
  reg [6:0] addr;
  reg a;
  reg [7:0] p;
  reg [15:0] v;
  reg two = 1'b1; // register under the pointer is two bytes wide
  reg pol_sr = 1'b0; // software reset of the polarity instance
  reg [3:0] dio = 4'h0; // diode per channel: 0 normal, 1 swapped, 2 open, 3 shorted
  wire [3:0] pol_src, pol_clm, pol_high;
  wire [6:0] pol_addr, pre_addr;
  wire pol_valid, pre_valid, wr_o;
  wire [7:0] wdata_o;
  integer n_wr = 0, j;
  // open drain with pull-up: low when either side pulls
  assign sda = !(m_low || (!sda_oe_n_o && !sda_o));
  tsi_slave #(.VARIANT(2'h0), .PROBE_CYC(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .address_select_upper_i(up), .address_select_upper_float_i(upf),
    .address_select_lower_i(lo), .address_select_lower_float_i(lof),
    .sensor_pin_high_i(pins), .probe_source_o(), .probe_clamp_o(), .reg_rdata_i(rdata),
    .reg_two_byte_i(two), .reg_ptr_o(reg_ptr_o), .reg_wr_o(wr_o), .reg_wdata_o(wdata_o),
    .soft_reset_i(1'b0), .conv_busy_i(busy), .conv_start_o(conv_start_o),
    .shutdown_control_o(shutdown_control_o), .hs_mode_o(hs_mode_o),
    .slave_addr_o(slave_addr_o), .addr_valid_o(addr_valid_o));
  tsi_bus_master m_u (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  // remote diode: a sourced pin rises unless current flows forward into a clamped partner
  function dhi(input [1:0] c, input jp, input clamped);
    begin
      dhi = (c == 2'h2) || (c == 2'h0 && jp) || (c == 2'h1 && !jp) || (c != 2'h3 && !clamped);
    end
  endfunction
  // polarity address: channel one sets bit one, channel two bit zero
  function [6:0] exp_pol(input [3:0] d);
    begin
      exp_pol = 7'h4C | {5'h00, d[1:0] == 2'h1, d[3:2] == 2'h1};
    end
  endfunction
  assign pol_high = {pol_src[3] && dhi(dio[3:2], 1'b1, pol_clm[2]),
                     pol_src[2] && dhi(dio[3:2], 1'b0, pol_clm[3]),
                     pol_src[1] && dhi(dio[1:0], 1'b1, pol_clm[0]),
                     pol_src[0] && dhi(dio[1:0], 1'b0, pol_clm[1])};
  // polarity variant, bus idle; settle long enough for the pin pipeline
  tsi_slave #(.VARIANT(2'h1), .PROBE_CYC(8)) pol_u (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(1'b1), .sda_i(1'b1), .sda_o(), .sda_oe_n_o(), .address_select_upper_i(1'b0),
    .address_select_upper_float_i(1'b0), .address_select_lower_i(1'b0),
    .address_select_lower_float_i(1'b0), .sensor_pin_high_i(pol_high),
    .probe_source_o(pol_src), .probe_clamp_o(pol_clm), .reg_rdata_i(16'h0000),
    .reg_two_byte_i(1'b1), .reg_ptr_o(), .reg_wr_o(), .reg_wdata_o(), .soft_reset_i(pol_sr),
    .conv_busy_i(1'b0), .conv_start_o(), .shutdown_control_o(), .hs_mode_o(),
    .slave_addr_o(pol_addr), .addr_valid_o(pol_valid));
  // preset variant: address must not follow the random sensor pins
  tsi_slave #(.VARIANT(2'h2), .PRESET_ADDR(7'h4D)) pre_u (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(1'b1), .sda_i(1'b1), .sda_o(), .sda_oe_n_o(), .address_select_upper_i(1'b0),
    .address_select_upper_float_i(1'b0), .address_select_lower_i(1'b0),
    .address_select_lower_float_i(1'b0), .sensor_pin_high_i(pins),
    .probe_source_o(), .probe_clamp_o(), .reg_rdata_i(16'h0000),
    .reg_two_byte_i(1'b1), .reg_ptr_o(), .reg_wr_o(), .reg_wdata_o(), .soft_reset_i(1'b0),
    .conv_busy_i(1'b0), .conv_start_o(), .shutdown_control_o(), .hs_mode_o(),
    .slave_addr_o(pre_addr), .addr_valid_o(pre_valid));
  initial forever #20 clk_i = ~clk_i;
  // count one-shot starts
  always @(posedge clk_i) if (conv_start_o === 1'b1) n_start <= n_start + 1;
  // count register write pulses
  always @(posedge clk_i) if (wr_o === 1'b1) n_wr <= n_wr + 1;
  // watchdog well beyond the expected run
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    conclude;
  end
  task chk(input [8*12:1] what, input [15:0] exp, input [15:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        $display("wrong value %0s expected %h seen %h", what, exp, got);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task conclude;
    begin
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task sync;
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // address from the strap table
  function [6:0] exp_addr(input u, input uf, input l, input lf);
    begin
      if (uf && lf) exp_addr = 7'h2A;
      else if (uf) exp_addr = 7'h1C + l;
      else if (lf) exp_addr = 7'h1E + u;
      else exp_addr = 7'h4C + {u, l};
    end
  endfunction
  // pointer write with an optional data byte; each byte acknowledged
  task wr(input [7:0] ptr, input has_d, input [7:0] d);
    begin
      m_u.start;
      m_u.wbyte({addr, 1'b0}, a);
      chk("waddr ack", 1'b0, a);
      m_u.wbyte(ptr, a);
      chk("ptr ack", 1'b0, a);
      if (has_d) m_u.wbyte(d, a);
      if (has_d) chk("data ack", 1'b0, a);
      m_u.stop;
    end
  endtask
  // two-byte read: first byte acknowledged, second not
  task rd(output [15:0] val);
    begin
      m_u.start;
      m_u.wbyte({addr, 1'b1}, a);
      chk("raddr ack", 1'b0, a);
      m_u.rbyte(1'b0, val[15:8]);
      m_u.rbyte(1'b1, val[7:0]);
      m_u.stop;
    end
  endtask
  initial begin
    for (k = 0; k < 9; k = k + 1) begin
      sync;
      rst_i = 1'b1;
      upf = (k % 3 == 2);
      up = (k % 3 == 1);
      lof = (k / 3 == 2);
      lo = (k / 3 == 1);
      pins = $random(seed);
      repeat (6) sync;
      rst_i = 1'b0;
      for (n = 0; n < 400 && addr_valid_o !== 1'b1; n = n + 1) sync;
      addr = exp_addr(up, upf, lo, lof);
      chk("address", addr, slave_addr_o);
    end
    // corner cases first (both normal, swapped, open, shorted), then random mixes
    for (j = 0; j < 6; j = j + 1) begin
      if (j < 4) dio = 4'h5 * j[3:0];
      else dio = $random(seed);
      sync;
      pol_sr = 1'b1;
      sync;
      pol_sr = 1'b0;
      sync;
      for (n = 0; n < 400 && pol_valid !== 1'b1; n = n + 1) sync;
      chk("polarity", exp_pol(dio), pol_addr);
    end
    chk("preset", {1'b1, 7'h4D}, {pre_valid, pre_addr});
    chk("ptr reset", 8'h00, reg_ptr_o);
    p = 8'h40 | ($random(seed) & 8'h3F);
    rdata = $random(seed);
    m_u.start;
    m_u.wbyte({addr, 1'b0}, a);
    m_u.wbyte(p, a);
    rd(v);
    chk("read word", rdata, v);
    chk("ptr only", p, reg_ptr_o);
    sync;
    rdata = $random(seed);
    rd(v);
    chk("reread", rdata, v);
    chk("ptr no wr", 0, n_wr);
    two = 1'b0;
    m_u.start;
    m_u.wbyte({addr, 1'b1}, a);
    m_u.rbyte(1'b1, p);
    m_u.stop;
    chk("one byte", rdata[15:8], p);
    two = 1'b1;
    m_u.start;
    m_u.wbyte({addr ^ 7'h01, 1'b0}, a);
    chk("foreign ack", 1'b1, a);
    m_u.stop;
    m_u.start;
    m_u.wbyte(8'h08 | ($random(seed) & 8'h07), a);
    chk("hs nack", 1'b1, a);
    chk("hs mode", 1'b1, hs_mode_o);
    rd(v);
    chk("hs read", rdata, v);
    chk("hs off", 1'b0, hs_mode_o);
    wr(8'h0F, 1'b1, $random(seed));
    chk("start sd0", 0, n_start);
    wr(8'h09, 1'b1, 8'h40);
    chk("shutdown", 1'b1, shutdown_control_o);
    chk("wdata", 8'h40, wdata_o);
    sync;
    busy = 1'b1;
    wr(8'h0F, 1'b1, $random(seed));
    chk("busy start", 0, n_start);
    sync;
    busy = 1'b0;
    wr(8'h0F, 1'b1, $random(seed));
    chk("one start", 1, n_start);
    chk("ptr trigger", 8'h0F, reg_ptr_o);
    chk("writes", 4, n_wr);
    conclude;
  end
endmodule
